// File: rtl/asr_pkg.sv
// asr_pkg: constants and types of the asynchronous serial receiver.
// assumes a single pclk domain and an APB register port.
package asr_pkg;

	// ***********************************************
	// register byte offsets
	// ***********************************************
	localparam logic [7:0] OFF_RX_STATUS_CTRL = 8'h00;
	localparam logic [7:0] OFF_RX_DATA        = 8'h04;
	localparam logic [7:0] OFF_TX_STATUS_CTRL = 8'h08;
	localparam logic [7:0] OFF_BAUD_CTRL      = 8'h0c;
	localparam logic [7:0] OFF_DIV_HIGH       = 8'h10;
	localparam logic [7:0] OFF_DIV_LOW        = 8'h14;
	localparam logic [7:0] OFF_IRQ_FLAGS      = 8'h18;
	localparam logic [7:0] OFF_IRQ_ENABLES    = 8'h1c;
	localparam logic [7:0] OFF_IRQ_PRIOS      = 8'h20;

	// ***********************************************
	// field positions
	// ***********************************************
	localparam int BIT_PORT_EN   = 7;
	localparam int BIT_NINE_EN   = 6;
	localparam int BIT_CONT_RX   = 4;
	localparam int BIT_ADDR_DET  = 3;
	localparam int BIT_FRAME_ERR = 2;
	localparam int BIT_OVERRUN   = 1;
	localparam int BIT_NINTH     = 0;
	localparam int BIT_SYNC      = 4;
	localparam int BIT_HI_SPEED  = 2;
	localparam int BIT_RX_IDLE   = 6;
	localparam int BIT_WIDE_DIV  = 3;
	localparam int BIT_WAKE_EN   = 1;
	localparam int BIT_RC_IRQ    = 5;

	// ***********************************************
	// reset values and sampling counts
	// ***********************************************
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [3:0] SPB_LAST_X16 = 4'hf;
	localparam logic [3:0] SPB_MID_X16  = 4'h7;
	localparam logic [3:0] SPB_LAST_X4  = 4'h3;
	localparam logic [3:0] SPB_MID_X4   = 4'h1;
	localparam logic [1:0] PRE_X64_LAST = 2'h3;
	localparam logic [3:0] LAST_BIT_8   = 4'h7;
	localparam logic [3:0] LAST_BIT_9   = 4'h8;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_STOP
	} asr_state_e;

	typedef struct packed {
		logic       framing_error;
		logic       ninth_bit;
		logic [7:0] data;
	} asr_char_s;

endpackage : asr_pkg

// File: rtl/asr_receiver.sv
// asr_receiver: async serial receive path with APB register port.
// assumes receive_line and sleep_mode are synchronous to pclk.
//
// Contract
// - recover bits with a 16x sample clock, 4x in the fastest setting, feeding a per-bit shifter
// - asynchronous operation only with sync select clear and port enable set
// - baud rate from divisor high and low with speed and width selects
// - nine-bit enable receives nine bits, ninth shown in status
// - characters received only while continuous receive enable is set
// - completed character sets receive flag; interrupt if enabled
// - status shows ninth bit and framing error of head character, and the latched overrun error
// - receive data register holds the low eight data bits
// - clearing continuous receive enable clears latched receive error
// - receive interrupt goes to high or low level by priority bit
// - address detect in nine-bit mode drops non-address characters
// - sleep stops baud generator and normal reception
// - wake-up enable suspends reception and watches line for wake event
// - falling edge on receive line is the wake event
// - wake event sets the receive flag
// - reading receive data clears the wake-caused flag; software discards it
// - wake-up enable auto-clears on next rising edge, then normal reception
// - wake-up function only available in asynchronous operation
// - frame: start bit, eight or nine data bits lsb first, stop bit
// - baud clock is 4x, 16x or 64x of bit rate per selects
`timescale 1ns/1ns
`default_nettype none

module asr_receiver #(
	parameter int DEPTH = 2
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        receive_line,
	input  wire logic        sleep_mode,
	output logic             irq_high,
	output logic             irq_low,
	output logic             wake_event
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ***********************************************
	// registers
	// ***********************************************
	logic [7:0]            rx_ctrl_reg;
	logic [7:0]            tx_ctrl_reg;
	logic [7:0]            baud_ctrl_reg;
	logic [7:0]            div_high_reg;
	logic [7:0]            div_low_reg;
	logic [7:0]            irq_en_reg;
	logic [7:0]            irq_pri_reg;
	logic                  overrun_reg;
	logic                  wake_flag_reg;
	logic                  woke_reg;
	logic                  line_prev_reg;
	logic [15:0]           brg_cnt_reg;
	logic [1:0]            pre_cnt_reg;
	asr_pkg::asr_state_e   state_reg;
	logic [3:0]            smp_cnt_reg;
	logic [3:0]            bit_cnt_reg;
	logic [8:0]            shift_reg;
	asr_pkg::asr_char_s    mem [DEPTH];
	logic [PW-1:0]         wr_ptr_reg;
	logic [PW-1:0]         rd_ptr_reg;
	logic [PW:0]           count_reg;

	logic                  async_en;
	logic                  wake_en;
	logic                  rx_run;
	logic                  wr_acc;
	logic                  rd_acc;
	logic                  pop;
	logic                  push;
	logic                  fifo_full;
	logic                  fifo_empty;
	logic                  brg_tick;
	logic                  smp_tick;
	logic                  fast_mode;
	logic [3:0]            spb_last;
	logic [3:0]            spb_mid;
	logic [3:0]            last_bit;
	logic [15:0]           divisor;
	logic                  done_char;
	logic                  admit;
	logic                  rx_flag;
	asr_pkg::asr_char_s    new_char;
	asr_pkg::asr_char_s    head;
	logic                  fall;
	logic                  rise;
	logic [7:0]            rd_next;
	logic                  err_next;

	assign async_en = rx_ctrl_reg[asr_pkg::BIT_PORT_EN] & ~tx_ctrl_reg[asr_pkg::BIT_SYNC];
	assign wake_en  = baud_ctrl_reg[asr_pkg::BIT_WAKE_EN] & async_en;
	assign rx_run   = async_en & rx_ctrl_reg[asr_pkg::BIT_CONT_RX] & ~wake_en & ~sleep_mode & ~overrun_reg;
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_acc   = psel & penable & pready & ~pwrite;
	assign fifo_full  = (count_reg == (PW+1)'(DEPTH));
	assign fifo_empty = (count_reg == '0);
	assign pop      = rd_acc & (paddr == asr_pkg::OFF_RX_DATA) & ~fifo_empty;
	assign head     = mem[rd_ptr_reg];
	assign rx_flag  = ~fifo_empty | wake_flag_reg;
	assign fall     = line_prev_reg & ~receive_line;
	assign rise     = ~line_prev_reg & receive_line;

	// ***********************************************
	// baud generator
	// ***********************************************
	// one brg tick every divisor+1 cycles; x64 modes divide it by four more
	assign divisor   = baud_ctrl_reg[asr_pkg::BIT_WIDE_DIV] ? {div_high_reg, div_low_reg} : {8'h00, div_low_reg};
	assign fast_mode = baud_ctrl_reg[asr_pkg::BIT_WIDE_DIV] & tx_ctrl_reg[asr_pkg::BIT_HI_SPEED];
	assign brg_tick  = (brg_cnt_reg == 16'h0000) & ~sleep_mode;
	assign smp_tick  = brg_tick & ((baud_ctrl_reg[asr_pkg::BIT_WIDE_DIV] | tx_ctrl_reg[asr_pkg::BIT_HI_SPEED])
		| (pre_cnt_reg == asr_pkg::PRE_X64_LAST));
	// the fastest setting leaves four brg ticks per bit, so it samples 4x not 16x
	assign spb_last  = fast_mode ? asr_pkg::SPB_LAST_X4 : asr_pkg::SPB_LAST_X16;
	assign spb_mid   = fast_mode ? asr_pkg::SPB_MID_X4 : asr_pkg::SPB_MID_X16;
	assign last_bit  = rx_ctrl_reg[asr_pkg::BIT_NINE_EN] ? asr_pkg::LAST_BIT_9 : asr_pkg::LAST_BIT_8;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brg_cnt_reg <= 16'h0000;
			pre_cnt_reg <= 2'h0;
		end else if (!async_en) begin
			brg_cnt_reg <= 16'h0000;
			pre_cnt_reg <= 2'h0;
		end else if (!sleep_mode) begin
			if (brg_cnt_reg == 16'h0000) begin
				brg_cnt_reg <= divisor;
				pre_cnt_reg <= pre_cnt_reg + 2'h1;
			end else begin
				brg_cnt_reg <= brg_cnt_reg - 16'h0001;
			end
		end
	end

	// ***********************************************
	// receive state machine
	// ***********************************************
	assign done_char = (state_reg == asr_pkg::ST_STOP) & smp_tick & (smp_cnt_reg == spb_mid);
	always_comb begin
		new_char.framing_error = ~receive_line;
		new_char.ninth_bit     = rx_ctrl_reg[asr_pkg::BIT_NINE_EN] & shift_reg[8];
		new_char.data          = rx_ctrl_reg[asr_pkg::BIT_NINE_EN] ? shift_reg[7:0] : shift_reg[8:1];
	end
	// address detect drops characters whose ninth bit is zero
	assign admit = ~(rx_ctrl_reg[asr_pkg::BIT_ADDR_DET] & rx_ctrl_reg[asr_pkg::BIT_NINE_EN] & ~shift_reg[8]);
	assign push  = done_char & admit & ~fifo_full;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= asr_pkg::ST_IDLE;
			smp_cnt_reg <= 4'h0;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 9'h000;
		end else if (!rx_run) begin
			state_reg   <= asr_pkg::ST_IDLE;
			smp_cnt_reg <= 4'h0;
			bit_cnt_reg <= 4'h0;
		end else begin
			unique case (state_reg)
				asr_pkg::ST_IDLE: begin
					smp_cnt_reg <= 4'h0;
					bit_cnt_reg <= 4'h0;
					// only a falling edge starts a frame, so a low stop bit is not retaken as a start
					if (fall) begin
						state_reg <= asr_pkg::ST_START;
					end
				end
				asr_pkg::ST_START: begin
					if (smp_tick) begin
						smp_cnt_reg <= smp_cnt_reg + 4'h1;
						// a start bit gone high by mid-bit was a glitch
						if (smp_cnt_reg == spb_mid && receive_line) begin
							state_reg <= asr_pkg::ST_IDLE;
						end else if (smp_cnt_reg == spb_last) begin
							smp_cnt_reg <= 4'h0;
							state_reg   <= asr_pkg::ST_DATA;
						end
					end
				end
				asr_pkg::ST_DATA: begin
					if (smp_tick) begin
						smp_cnt_reg <= smp_cnt_reg + 4'h1;
						if (smp_cnt_reg == spb_mid) begin
							shift_reg <= {receive_line, shift_reg[8:1]};
						end
						if (smp_cnt_reg == spb_last) begin
							smp_cnt_reg <= 4'h0;
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == last_bit) begin
								state_reg <= asr_pkg::ST_STOP;
							end
						end
					end
				end
				asr_pkg::ST_STOP: begin
					if (smp_tick) begin
						smp_cnt_reg <= smp_cnt_reg + 4'h1;
						if (done_char) begin
							state_reg <= asr_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ***********************************************
	// receive buffer and errors
	// ***********************************************
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= new_char;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
			end
			if (push && !pop) begin
				count_reg <= count_reg + (PW+1)'(1);
			end else if (pop && !push) begin
				count_reg <= count_reg - (PW+1)'(1);
			end
		end
	end

	// overrun latches and halts reception until continuous receive is cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_reg <= 1'b0;
		end else if (done_char && admit && fifo_full) begin
			overrun_reg <= 1'b1;
		end else if (!rx_ctrl_reg[asr_pkg::BIT_CONT_RX]) begin
			overrun_reg <= 1'b0;
		end
	end

	// ***********************************************
	// wake-up on falling receive line
	// ***********************************************
	// sleep only stops the baud path and reception; pclk keeps running for this watcher
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_prev_reg <= 1'b1;
		end else begin
			line_prev_reg <= receive_line;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			woke_reg <= 1'b0;
		end else if (!wake_en) begin
			woke_reg <= 1'b0;
		end else if (fall && !woke_reg) begin
			woke_reg <= 1'b1;
		end else if (rise && woke_reg) begin
			woke_reg <= 1'b0;
		end
	end

	// a wake event in the cycle of the clearing read still sets the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_flag_reg <= 1'b0;
		end else if (wake_en && fall && !woke_reg) begin
			wake_flag_reg <= 1'b1;
		end else if (rd_acc && paddr == asr_pkg::OFF_RX_DATA) begin
			wake_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_event <= 1'b0;
		end else begin
			wake_event <= wake_en & fall & ~woke_reg;
		end
	end

	// ***********************************************
	// register writes
	// ***********************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ctrl_reg   <= asr_pkg::RST_BYTE;
			tx_ctrl_reg   <= asr_pkg::RST_BYTE;
			baud_ctrl_reg <= asr_pkg::RST_BYTE;
			div_high_reg  <= asr_pkg::RST_BYTE;
			div_low_reg   <= asr_pkg::RST_BYTE;
			irq_en_reg    <= asr_pkg::RST_BYTE;
			irq_pri_reg   <= asr_pkg::RST_BYTE;
		end else begin
			if (wake_en && woke_reg && rise) begin
				baud_ctrl_reg[asr_pkg::BIT_WAKE_EN] <= 1'b0;
			end
			if (wr_acc) begin
				unique case (paddr)
					asr_pkg::OFF_RX_STATUS_CTRL: rx_ctrl_reg <= pwdata[7:0] & 8'hd8;
					asr_pkg::OFF_TX_STATUS_CTRL: tx_ctrl_reg <= pwdata[7:0] & 8'h14;
					asr_pkg::OFF_BAUD_CTRL:      baud_ctrl_reg <= pwdata[7:0] & 8'h0a;
					asr_pkg::OFF_DIV_HIGH:       div_high_reg <= pwdata[7:0];
					asr_pkg::OFF_DIV_LOW:        div_low_reg <= pwdata[7:0];
					asr_pkg::OFF_IRQ_ENABLES:    irq_en_reg <= pwdata[7:0] & 8'h20;
					asr_pkg::OFF_IRQ_PRIOS:      irq_pri_reg <= pwdata[7:0] & 8'h20;
					default: begin
					end
				endcase
			end
		end
	end

	// ***********************************************
	// apb read path and answer
	// ***********************************************
	always_comb begin
		rd_next  = 8'h00;
		err_next = 1'b0;
		unique case (paddr)
			asr_pkg::OFF_RX_STATUS_CTRL: begin
				rd_next = rx_ctrl_reg;
				rd_next[asr_pkg::BIT_FRAME_ERR] = ~fifo_empty & head.framing_error;
				rd_next[asr_pkg::BIT_OVERRUN]   = overrun_reg;
				rd_next[asr_pkg::BIT_NINTH]     = ~fifo_empty & head.ninth_bit;
			end
			asr_pkg::OFF_RX_DATA:        rd_next = fifo_empty ? 8'h00 : head.data;
			asr_pkg::OFF_TX_STATUS_CTRL: rd_next = tx_ctrl_reg;
			asr_pkg::OFF_BAUD_CTRL: begin
				rd_next = baud_ctrl_reg;
				rd_next[asr_pkg::BIT_RX_IDLE] = (state_reg == asr_pkg::ST_IDLE);
			end
			asr_pkg::OFF_DIV_HIGH:       rd_next = div_high_reg;
			asr_pkg::OFF_DIV_LOW:        rd_next = div_low_reg;
			asr_pkg::OFF_IRQ_FLAGS:      rd_next = {2'h0, rx_flag, 5'h00};
			asr_pkg::OFF_IRQ_ENABLES:    rd_next = irq_en_reg;
			asr_pkg::OFF_IRQ_PRIOS:      rd_next = irq_pri_reg;
			default:                     err_next = 1'b1;
		endcase
	end

	// answer is prepared in the setup cycle so the access cycle has no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_next} : 32'h0000_0000;
			pslverr <= psel & ~penable & err_next;
		end
	end

	// ***********************************************
	// interrupt requests
	// ***********************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_high <= 1'b0;
			irq_low  <= 1'b0;
		end else begin
			irq_high <= rx_flag & irq_en_reg[asr_pkg::BIT_RC_IRQ] & irq_pri_reg[asr_pkg::BIT_RC_IRQ];
			irq_low  <= rx_flag & irq_en_reg[asr_pkg::BIT_RC_IRQ] & ~irq_pri_reg[asr_pkg::BIT_RC_IRQ];
		end
	end

endmodule : asr_receiver

`default_nettype wire

// File: sim/asr_receiver_assertions.sv
// asr_receiver_checker: port-level properties of the serial receiver.
// assumes it is bound into asr_receiver and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module asr_receiver_checker #(
	parameter int DEPTH = 2
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        receive_line,
	input wire logic        sleep_mode,
	input wire logic        irq_high,
	input wire logic        irq_low,
	input wire logic        wake_event
);
	// ****************
	// enable and priority shadows
	// ****************
	// shadows follow completed writes so irq levels can be tied to their cause
	logic en_q;
	logic pr_q;
	logic acc_wr;
	assign acc_wr = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0;
			pr_q <= 1'b0;
		end else if (acc_wr && paddr == asr_pkg::OFF_IRQ_ENABLES) begin
			en_q <= pwdata[asr_pkg::BIT_RC_IRQ];
		end else if (acc_wr && paddr == asr_pkg::OFF_IRQ_PRIOS) begin
			pr_q <= pwdata[asr_pkg::BIT_RC_IRQ];
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ****************
	// properties
	// ****************
	a_ready_after_setup: assert property (psel && !penable |=> pready ##1 !pready) else $error("ready not single");
	a_no_stray_ready: assert property (!(psel && !penable) |=> !pready) else $error("stray ready");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h20 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	a_irq_exclusive: assert property (!(irq_high && irq_low)) else $error("both irq levels");
	a_irq_high_cause: assert property (irq_high |-> $past(en_q) && $past(pr_q)) else $error("bad high irq");
	a_irq_low_cause: assert property (irq_low |-> $past(en_q) && !$past(pr_q)) else $error("bad low irq");
	a_wake_pulse: assert property (wake_event |=> !wake_event) else $error("wake pulse too long");
	a_wake_irq: assert property (wake_event && en_q && pr_q |-> ##[0:2] irq_high) else $error("no wake irq");
endmodule : asr_receiver_checker

bind asr_receiver asr_receiver_checker #(.DEPTH(DEPTH)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.receive_line(receive_line), .sleep_mode(sleep_mode), .irq_high(irq_high),
	.irq_low(irq_low), .wake_event(wake_event)
);
`default_nettype wire

// File: sim/asr_line_driver.sv
// asr_line_driver: far-end transmitter model on the receive line.
// assumes pclk is the receiver clock; bit length is given in pclk cycles.
`timescale 1ns/1ns
`default_nettype none

module asr_line_driver (
	input  wire logic pclk,
	output var logic  receive_line
);
	// ****************
	// line drive
	// ****************
	// the line rests at its high mark level between frames
	initial receive_line = 1'b1;

	task automatic level(input logic v, input int n);
		@(posedge pclk);
		receive_line <= v;
		repeat (n) @(posedge pclk);
	endtask : level

	// a low stop bit is only sent to provoke a framing error
	task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bitc);
		level(1'b0, bitc - 1);
		for (int i = 0; i < nb; i++) level(d[i], bitc - 1);
		level(stop, bitc - 1);
		if (!stop) level(1'b1, bitc - 1);
	endtask : send
endmodule : asr_line_driver
`default_nettype wire

// File: sim/async_serial_receiver_test.sv
// async_serial_receiver_test: self-checking bench of the serial receiver.
// assumes asr_pkg, asr_receiver, its checker and the line driver compile first.
`timescale 1ns/1ns
`default_nettype none

module async_serial_receiver_test;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        receive_line;
	logic        sleep_mode;
	logic        irq_high;
	logic        irq_low;
	logic        wake_event;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [8:0]  b;
	logic [7:0]  bq[3];
	int          bitc;
	int          num_errors;
	int          total_checks;
	int          wake_cnt;
	int          cyc;
	integer      seed;
	int          md[4][4] = '{'{0, 0, 0, 64}, '{0, 1, 1, 32}, '{1, 1, 3, 16}, '{1, 0, 1, 32}};

	asr_receiver #(.DEPTH(2)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.receive_line(receive_line), .sleep_mode(sleep_mode), .irq_high(irq_high),
		.irq_low(irq_low), .wake_event(wake_event)
	);
	asr_line_driver line_u (.pclk(pclk), .receive_line(receive_line));

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// the request is held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) begin
			check(33'h0, 33'h1);
			complete_run();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// bit 33 of a note skips the compare, bit 32 is the expected pslverr
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic tx(input logic nine, input int nb, input logic stop);
		b = {nine, 8'($random(seed))};
		line_u.send(b, nb, stop, bitc);
	endtask : tx

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (wake_event === 1'b1) wake_cnt++;
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (!e[33]) check({pslverr, prdata}, e[32:0]);
		end
		if (cyc == 40000) begin
			num_errors++;
			complete_run();
		end
	end

	initial begin
		seed = 56894;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		sleep_mode = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// the idle receiver shows its idle status bit in baud control
		for (int a = 0; a < 9; a++) rd(8'(a * 4), (a == 3) ? 34'h40 : 34'h0);
		rd(8'h24, 34'h1_0000_0000);
		apb(1'b1, 8'h1c, 32'h20);
		apb(1'b1, 8'h20, 32'h20);
		apb(1'b1, 8'h00, 32'h90);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 8'h08, 32'(md[m][0] * 4));
			apb(1'b1, 8'h0c, 32'(md[m][1] * 8));
			apb(1'b1, 8'h14, 32'(md[m][2]));
			bitc = md[m][3];
			tx(1'b0, 8, 1'b1);
			repeat (2) @(posedge pclk);
			check(33'({irq_high, irq_low}), 33'h2);
			rd(8'h00, 34'h90);
			rd(8'h04, 34'(b[7:0]));
			rd(8'h18, 34'h0);
		end
		apb(1'b1, 8'h10, 32'h1);
		apb(1'b1, 8'h20, 32'h0);
		tx(1'b0, 8, 1'b1);
		repeat (2) @(posedge pclk);
		check(33'({irq_high, irq_low}), 33'h1);
		rd(8'h04, 34'(b[7:0]));
		// interrupt masked while the buffer overflows
		apb(1'b1, 8'h1c, 32'h0);
		for (int k = 0; k < 3; k++) begin
			tx(1'b0, 8, 1'b1);
			bq[k] = b[7:0];
		end
		check(33'({irq_high, irq_low}), 33'h0);
		rd(8'h00, 34'h92);
		rd(8'h04, 34'(bq[0]));
		rd(8'h04, 34'(bq[1]));
		apb(1'b1, 8'h00, 32'h80);
		rd(8'h00, 34'h80);
		tx(1'b0, 8, 1'b1);
		rd(8'h18, 34'h0);
		apb(1'b1, 8'h1c, 32'h20);
		apb(1'b1, 8'h20, 32'h20);
		apb(1'b1, 8'h00, 32'h90);
		apb(1'b1, 8'h08, 32'h14);
		tx(1'b0, 8, 1'b1);
		rd(8'h18, 34'h0);
		apb(1'b1, 8'h08, 32'h4);
		tx(1'b0, 8, 1'b0);
		rd(8'h00, 34'h94);
		rd(8'h04, 34'(b[7:0]));
		apb(1'b1, 8'h00, 32'hd8);
		tx(1'b0, 9, 1'b1);
		tx(1'b1, 9, 1'b1);
		rd(8'h00, 34'hd9);
		rd(8'h04, 34'(b[7:0]));
		rd(8'h18, 34'h0);
		apb(1'b1, 8'h00, 32'hd0);
		tx(1'b0, 9, 1'b1);
		rd(8'h00, 34'hd0);
		rd(8'h04, 34'(b[7:0]));
		apb(1'b1, 8'h00, 32'h90);
		sleep_mode <= 1'b1;
		tx(1'b0, 8, 1'b1);
		rd(8'h18, 34'h0);
		apb(1'b1, 8'h0c, 32'h2);
		line_u.level(1'b0, 40);
		check(33'(wake_cnt), 33'h1);
		check(33'(irq_high), 33'h1);
		rd(8'h18, 34'h20);
		rd(8'h0c, 34'h42);
		line_u.level(1'b1, 4);
		rd(8'h0c, 34'h40);
		rd(8'h04, 34'h2_0000_0000);
		rd(8'h18, 34'h0);
		sleep_mode <= 1'b0;
		tx(1'b0, 8, 1'b1);
		rd(8'h04, 34'(b[7:0]));
		complete_run();
	end
endmodule : async_serial_receiver_test
`default_nettype wire
